/* File: hdl/bkrs_defines.vh */
// Constants for the buck regulator control sequencer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef BKRS_DEFINES_VH
`define BKRS_DEFINES_VH

// Register offsets
`define BKRS_ADDR_SETUP 4'h0
`define BKRS_ADDR_TARGET 4'h1
`define BKRS_ADDR_FLAGMASK 4'h2
`define BKRS_ADDR_STATUS 4'h3
`define BKRS_ADDR_IRQ 4'h4
`define BKRS_ADDR_IRQMASK 4'h5

// Setup register fields
`define BKRS_SETUP_CONV_ON 0
`define BKRS_SETUP_BLEED 1
`define BKRS_SETUP_FOP_LO 2
`define BKRS_SETUP_FOP_HI 3
`define BKRS_SETUP_RESET 8'h01

// Flag mask register: overcurrent response field
`define BKRS_OCR_LO 0
`define BKRS_OCR_HI 1
`define BKRS_OCR_HICCUP 2'h0
`define BKRS_OCR_SHUTDOWN 2'h1
`define BKRS_OCR_LIMIT 2'h2

// Forced operation select codes
`define BKRS_FOP_AUTO 2'h0
`define BKRS_FOP_PWM 2'h2

// Interrupt event bit positions
`define BKRS_EV_OC 0
`define BKRS_EV_THERM 1
`define BKRS_EV_READY 2
`define BKRS_EV_COUNT 3

// Timing
`define BKRS_CLK_MHZ 100
`define BKRS_HICCUP_MS 100
`define BKRS_HICCUP_CYC (`BKRS_HICCUP_MS * 1000 * `BKRS_CLK_MHZ)
`define BKRS_DEAD_CYC 4'h3
`define BKRS_INIT_CYC 8'h10
`define BKRS_RAMP_DIV 16'h0064
`define BKRS_OTP_DEF_TARGET 8'h40
`define BKRS_OTP_DEF_RATE 4'h1

`endif

/* File: hdl/bkrs_pwm_driver.v */
// Pulse-width switch sequencer: high side, dead time, low side, dead time.
// Assumes comparator flags already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
`include "bkrs_defines.vh"

module bkrs_pwm_driver (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Control
  input wire run,
  input wire curLimitMode,
  // Comparators
  input wire upperHit,
  input wire lowerHit,
  input wire peakHit,
  // Switch drives
  output reg highSideOn,
  output reg lowSideOn
);

  localparam HIGH = 2'h0;
  localparam DEAD1 = 2'h1;
  localparam LOW = 2'h2;
  localparam DEAD2 = 2'h3;

  reg [1:0] state_q; // Phase of the switching cycle
  reg [3:0] dead_q; // Dead-time counter

  // Phase machine; both drives off whenever not running
  always @(posedge clk) begin
    if (reset || !run) begin
      state_q <= DEAD2;
      dead_q <= `BKRS_DEAD_CYC;
      highSideOn <= 1'b0;
      lowSideOn <= 1'b0;
    end else begin
      case (state_q)
        HIGH: begin
          // Peak cap also ends the on-time in limit mode
          if (upperHit || (curLimitMode && peakHit)) begin
            highSideOn <= 1'b0;
            dead_q <= `BKRS_DEAD_CYC;
            state_q <= DEAD1;
          end
        end
        DEAD1: begin
          if (dead_q == 4'h1) begin
            lowSideOn <= 1'b1;
            state_q <= LOW;
          end else begin
            dead_q <= dead_q - 4'h1;
          end
        end
        LOW: begin
          if (lowerHit) begin
            lowSideOn <= 1'b0;
            dead_q <= `BKRS_DEAD_CYC;
            state_q <= DEAD2;
          end
        end
        default: begin
          if (dead_q == 4'h1) begin
            highSideOn <= 1'b1;
            state_q <= HIGH;
          end else begin
            dead_q <= dead_q - 4'h1;
          end
        end
      endcase
    end
  end

endmodule // bkrs_pwm_driver
`default_nettype wire

/* File: hdl/bkrs_sequencer.v */
// Control sequencer of a step-down regulator: enable, start-up, faults,
// bypass and PWM switching. Assumes synchronous pin and supply inputs, 100 MHz clock,
// and a simple strobe register port driven by a host.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bkrs_defines.vh"

// Notes on behaviour
// - Chip-on high runs; low powers down
// - Bleed set, converter off: discharge path on
// - Start after lockout clear and chip-on
// - Soft-start ramps output to target
// - Peak current picks response by select field
// - Hiccup: off 100 ms, retry, repeat
// - Shutdown latch cleared by supply/pin/bit cycle; over-temperature here also releases it via THERMAL
// - Current limit keeps switching, caps peak
// - Over-temperature stops switching and waits
// - Thermal release repeats soft-start then regulates
// - Bypass variant bypasses when input near output
// - PWM: high, dead, low, dead, repeat
// - PWM on heavy load or forced code
module bkrs_sequencer #(
  parameter HICCUP_CYC = `BKRS_HICCUP_CYC, // Shorten for simulation
  parameter HAS_BYPASS = 1 // Zero for variant without bypass
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Pins and supply status
  input wire chipOn,
  input wire supplyOk,
  // Analog comparators, asynchronous to clk
  input wire peakLimit,
  input wire overTemp,
  input wire upperThresh,
  input wire lowerThresh,
  input wire heavyLoad,
  input wire nearInput,
  input wire outputAtLevel,
  // One-time memory
  input wire otpValid,
  input wire [7:0] otpTarget,
  input wire [3:0] otpRate,
  // Register port
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  // Power stage
  output wire highSideOn,
  output wire lowSideOn,
  output reg bleedOn,
  output reg [7:0] rampLevel,
  output reg otpReadReq,
  // Interrupt
  output wire irq
);

  // Sequencer states
  localparam OFF = 3'h0;
  localparam INIT = 3'h1;
  localparam OTP = 3'h2;
  localparam RAMP = 3'h3;
  localparam REG = 3'h4;
  localparam HICCUP = 3'h5;
  localparam LATCHED = 3'h6;
  localparam THERMAL = 3'h7;

  reg [2:0] state_q; // Sequencer state
  reg [7:0] setup_q; // Converter setup register
  reg [7:0] target_q; // Output target level
  reg [7:0] flagMask_q; // Flag mask, holds response select
  reg [3:0] rate_q; // Ramp step size
  reg [2:0] irqStat_q; // Sticky events
  reg [2:0] irqMask_q; // Event enables
  reg [31:0] timer_q; // Hiccup and init timer
  reg [15:0] rampDiv_q; // Ramp pacing divider
  reg [4:0] sync1_q; // Synchroniser first stage
  reg [4:0] sync2_q; // Synchroniser second stage
  reg convOnPrev_q; // For bit cycle detection
  reg chipOnPrev_q; // For pin cycle detection
  reg supplyPrev_q; // For supply cycle detection

  wire pkS = sync2_q[0];
  wire otS = sync2_q[1];
  wire upS = sync2_q[2];
  wire loS = sync2_q[3];
  wire hvS = sync2_q[4];
  wire convOn = setup_q[`BKRS_SETUP_CONV_ON];
  wire [1:0] ocSel = flagMask_q[`BKRS_OCR_HI:`BKRS_OCR_LO];
  wire [1:0] fopSel = setup_q[`BKRS_SETUP_FOP_HI:`BKRS_SETUP_FOP_LO];
  wire enabled = chipOn && supplyOk;
  wire bypassNow = (HAS_BYPASS != 0) && nearInput;
  wire pwmMode = (fopSel == `BKRS_FOP_PWM) || hvS;
  wire switching = (state_q == RAMP || state_q == REG) && !bypassNow;
  wire [2:0] events; // Event pulses this cycle
  wire wrIrq = regWrite && (regAddr == `BKRS_ADDR_IRQ);

  // Comparator synchronisers; stage one only feeds stage two
  always @(posedge clk) begin
    if (reset) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {heavyLoad, lowerThresh, upperThresh, overTemp, peakLimit};
      sync2_q <= sync1_q;
    end
  end

  // Switching phases; only in pulse-width mode while ramping or regulating, not in bypass
  bkrs_pwm_driver uDriver (
    .clk(clk),
    .reset(reset),
    .run(switching && pwmMode),
    .curLimitMode(ocSel == `BKRS_OCR_LIMIT),
    .upperHit(upS),
    .lowerHit(loS),
    .peakHit(pkS),
    .highSideOn(highSideOn),
    .lowSideOn(lowSideOn)
  );

  // Register writes from the host
  always @(posedge clk) begin
    if (reset) begin
      setup_q <= `BKRS_SETUP_RESET;
      flagMask_q <= 8'h00;
      irqMask_q <= 3'h0;
    end else if (regWrite) begin
      case (regAddr)
        `BKRS_ADDR_SETUP: setup_q <= regWdata;
        `BKRS_ADDR_FLAGMASK: flagMask_q <= regWdata;
        `BKRS_ADDR_IRQMASK: irqMask_q <= regWdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data, valid the cycle after the strobe
  always @(posedge clk) begin
    if (reset) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `BKRS_ADDR_SETUP: regRdata <= setup_q;
        `BKRS_ADDR_TARGET: regRdata <= target_q;
        `BKRS_ADDR_FLAGMASK: regRdata <= flagMask_q;
        `BKRS_ADDR_STATUS: regRdata <= {bypassNow, pwmMode, 3'h0, state_q};
        `BKRS_ADDR_IRQ: regRdata <= {5'h00, irqStat_q};
        `BKRS_ADDR_IRQMASK: regRdata <= {5'h00, irqMask_q};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Event pulses feeding the sticky status
  assign events[`BKRS_EV_OC] = switching && pkS && (ocSel != `BKRS_OCR_LIMIT);
  assign events[`BKRS_EV_THERM] = (state_q != THERMAL) && (state_q != OFF) && otS;
  assign events[`BKRS_EV_READY] = (state_q == RAMP) && (rampLevel == target_q);

  // Sticky status, write one to clear; a new event wins over the clear
  always @(posedge clk) begin
    if (reset) begin
      irqStat_q <= 3'h0;
    end else begin
      irqStat_q <= (irqStat_q & ~(wrIrq ? regWdata[2:0] : 3'h0)) | events;
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // Main sequencer
  // Overview of the state walk:
  // OFF waits for pin, supply and converter bit together
  // INIT counts a short settle before the memory request
  // OTP waits for the memory reply, then loads target and rate
  // RAMP steps the level up every divider period
  // REG holds the level at the register target
  // HICCUP waits out the retry interval, then ramps again
  // LATCHED holds off until the converter bit is cleared
  // THERMAL holds off until the hot flag drops
  //
  // Priority inside the enabled branch:
  // Converter bit cleared first, so software wins except in LATCHED, where over-temperature wins
  // Over-temperature second, it protects the silicon
  // Overcurrent last, only acts while switching
  //
  // Pin or supply low overrides everything, any state
  // Pin filtering is left to the host on purpose
  // A short low glitch therefore powers the block down
  // Trade-off: no extra counter, simpler restart timing
  //
  // Ramp pacing notes:
  // Divider free-runs while in RAMP
  // First step may come early after re-entry
  // Step is clamped so the level never passes target
  // Clamp uses a 9-bit difference to avoid wrap
  //
  // Hiccup timing notes:
  // Timer cleared on the fault edge itself
  // Restart comes after the full parameter count
  // Simulation shortens the count by parameter
  // Each retry goes back through soft-start
  // A recurring fault simply repeats the cycle
  //
  // Latched shutdown notes:
  // A converter bit cycle exits the state here; over-temperature sends it to THERMAL
  // Pin and supply cycles leave through the power-down path
  // Both paths land in OFF and restart from INIT
  //
  // Thermal notes:
  // Exit relies on comparator hysteresis
  // No extra margin counted in this block
  // Exit always restarts the soft-start ramp
  // Regulation then resumes at the register target
  //
  // Target register notes:
  // Host writes land in any state
  // Memory load at start overwrites an earlier write
  // Limitation: a lowered target steps the level down at once
  //
  // Bleed path notes:
  // Discharge only with pin high and converter bit low
  // Registered, so it follows the bit one cycle late
  // Can overlap the switching drives for one cycle after the bit clears
  //
  // Bypass notes:
  // Bypass stops the switching drives
  // Near-input flag is a level, not synchronised
  // Variant without bypass ignores the flag
  //
  // Memory request is a single-cycle pulse
  // A missing reply leaves the block in OTP
  // Recovery from that needs a power-down
  always @(posedge clk) begin
    if (reset) begin
      state_q <= OFF;
      target_q <= 8'h00;
      rate_q <= 4'h0;
      rampLevel <= 8'h00;
      rampDiv_q <= 16'h0000;
      timer_q <= 32'h0;
      otpReadReq <= 1'b0;
      bleedOn <= 1'b0;
      convOnPrev_q <= 1'b0;
      chipOnPrev_q <= 1'b0;
      supplyPrev_q <= 1'b0;
    end else begin
      convOnPrev_q <= convOn;
      chipOnPrev_q <= chipOn;
      supplyPrev_q <= supplyOk;
      otpReadReq <= 1'b0;
      // Discharge only with pin high and converter bit cleared
      bleedOn <= chipOn && setup_q[`BKRS_SETUP_BLEED] && !convOn;
      // Host may move the target while running
      if (regWrite && regAddr == `BKRS_ADDR_TARGET) begin
        target_q <= regWdata;
      end
      if (!enabled) begin
        // Power-down; the host keeps the pin low long enough
        state_q <= OFF;
        rampLevel <= 8'h00;
      end else begin
        case (state_q)
          OFF: begin
            timer_q <= 32'h0;
            if (convOn) begin
              state_q <= INIT;
            end
          end
          INIT: begin
            timer_q <= timer_q + 32'h1;
            if (timer_q[7:0] == `BKRS_INIT_CYC) begin
              otpReadReq <= 1'b1;
              state_q <= OTP;
            end
          end
          OTP: begin
            if (otpValid) begin
              target_q <= otpTarget;
              rate_q <= otpRate;
              rampLevel <= 8'h00;
              state_q <= RAMP;
            end
          end
          RAMP: begin
            rampDiv_q <= rampDiv_q + 16'h1;
            if (rampLevel == target_q) begin
              state_q <= REG;
            end else if (rampDiv_q == `BKRS_RAMP_DIV) begin
              rampDiv_q <= 16'h0000;
              // Step at programmed rate, clamp to target
              if ({1'b0, target_q} - {1'b0, rampLevel} <= {5'h00, rate_q}) begin
                rampLevel <= target_q;
              end else begin
                rampLevel <= rampLevel + {4'h0, rate_q};
              end
            end
          end
          REG: begin
            rampLevel <= target_q;
          end
          HICCUP: begin
            timer_q <= timer_q + 32'h1;
            if (timer_q == HICCUP_CYC - 1) begin
              rampLevel <= 8'h00;
              state_q <= RAMP;
            end
          end
          LATCHED: begin
            // Bit cycle restarts; pin and supply handled above
            if (!convOn) begin
              state_q <= OFF;
            end
          end
          default: begin
            // Wait for release, then soft-start again
            if (!otS) begin
              rampLevel <= 8'h00;
              state_q <= RAMP;
            end
          end
        endcase
        // Converter bit cleared in any active state powers down
        if (!convOn && state_q != LATCHED) begin
          state_q <= OFF;
          rampLevel <= 8'h00;
        end else if (otS && state_q != OFF && state_q != THERMAL) begin
          state_q <= THERMAL;
          rampLevel <= 8'h00;
        end else if (events[`BKRS_EV_OC]) begin
          rampLevel <= 8'h00;
          timer_q <= 32'h0;
          if (ocSel == `BKRS_OCR_SHUTDOWN) begin
            state_q <= LATCHED;
          end else begin
            state_q <= HICCUP;
          end
        end
      end
    end
  end

endmodule // bkrs_sequencer
`default_nettype wire

/* File: test/bkrs_seq_props.sv */
// Port checker of the sequencer: switch timing, start-up, bus.
// Bound to every bkrs_sequencer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bkrs_seq_props (
  // Clock and pins
  input wire clk,
  input wire reset,
  input wire chipOn,
  input wire supplyOk,
  input wire overTemp,
  // Register port
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdata,
  // Power stage
  input wire highSideOn,
  input wire lowSideOn,
  input wire bleedOn,
  input wire [7:0] rampLevel,
  input wire otpReadReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Both drives off for the fixed dead time
  sequence s_dead;
    (!highSideOn && !lowSideOn) [*3];
  endsequence
  a_no_overlap: assert property (!(highSideOn && lowSideOn)) else $error("drives overlap");
  a_dead_high: assert property ($fell(highSideOn) |-> s_dead) else $error("short dead after high");
  a_dead_low: assert property ($fell(lowSideOn) |-> s_dead) else $error("short dead after low");
  a_pin_off: assert property (!chipOn [*4] |-> !highSideOn && !lowSideOn && rampLevel == 8'h00)
    else $error("runs with pin low");
  a_therm_stop: assert property (overTemp [*6] |-> !highSideOn && !lowSideOn)
    else $error("switches while hot");
  a_bleed_on: assert property (regWrite && regAddr == 4'h0 && regWdata[1:0] == 2'h2 && chipOn
    |-> ##[1:3] bleedOn) else $error("no discharge");
  a_otp_start: assert property (otpReadReq |-> $past(chipOn, 2) && $past(supplyOk, 2) ##1 !otpReadReq)
    else $error("bad memory request");
  a_ramp_up: assert property (rampLevel != 8'h00 && $changed(rampLevel) |-> rampLevel > $past(rampLevel))
    else $error("ramp fell");
  a_read_idle: assert property (!regRead |=> regRdata == 8'h00) else $error("stray read data");
endmodule // bkrs_seq_props
bind bkrs_sequencer bkrs_seq_props i_props (.clk(clk), .reset(reset), .chipOn(chipOn),
  .supplyOk(supplyOk), .overTemp(overTemp), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .highSideOn(highSideOn),
  .lowSideOn(lowSideOn), .bleedOn(bleedOn), .rampLevel(rampLevel), .otpReadReq(otpReadReq));
`default_nettype wire

/* File: test/bkrs_stage_model.sv */
// Far side: coarse inductor current with hysteretic comparators, memory.
// Assumes drives never overlap.
`timescale 1ns/1ps
`default_nettype none
module bkrs_stage_model (
  // Clock and drives
  input wire logic clk,
  input wire logic highSideOn,
  input wire logic lowSideOn,
  input wire logic otpReadReq,
  // Memory content
  input wire logic [7:0] tgt,
  input wire logic [3:0] rate,
  // Replies
  output logic upperThresh,
  output logic lowerThresh,
  output logic otpValid,
  output logic [7:0] otpTarget,
  output logic [3:0] otpRate
);
  logic [3:0] cur = 4'h0; // Coarse inductor current
  logic [2:0] dly = 3'h0; // Memory access time
  // Current climbs on high side, falls on low side
  always @(posedge clk) begin
    if (highSideOn && cur != 4'hf) cur <= cur + 4'h1;
    else if (lowSideOn && cur != 4'h0) cur <= cur - 4'h1;
  end
  assign upperThresh = cur >= 4'ha;
  assign lowerThresh = cur <= 4'h2;
  // Reply late; junk outside the valid cycle
  always @(posedge clk) begin
    if (otpReadReq) dly <= 3'h5;
    else if (dly != 3'h0) dly <= dly - 3'h1;
  end
  assign otpValid = dly == 3'h1;
  assign otpTarget = otpValid ? tgt : ~tgt;
  assign otpRate = otpValid ? rate : ~rate;
endmodule // bkrs_stage_model
`default_nettype wire

/* File: test/bkrs_sequencer_tb_top.sv */
// Bench of the sequencer with far-side model.
// Hiccup interval shortened to 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module bkrs_sequencer_tb_top;
  logic clk, reset = 1'h1, chipOn = 1'h0, supplyOk = 1'h0, peakLimit = 1'h0, overTemp = 1'h0;
  logic heavyLoad = 1'h0, nearInput = 1'h0, regWrite = 1'h0, regRead = 1'h0, i0;
  logic [3:0] regAddr = 4'h0, rate;
  logic [7:0] regWdata = 8'h00, tgt, d;
  logic [7:0] regRdata, rampLevel, otpTarget;
  logic [3:0] otpRate;
  logic highSideOn, lowSideOn, bleedOn, otpReadReq, irq, upperThresh, lowerThresh, otpValid;
  int fails = 0, checks_done = 0, hsRise = 0, n;
  integer seed = 32'hc66f;
  bkrs_sequencer #(.HICCUP_CYC(50), .HAS_BYPASS(1)) i_bkrs_sequencer (.clk(clk), .reset(reset),
    .chipOn(chipOn), .supplyOk(supplyOk), .peakLimit(peakLimit), .overTemp(overTemp),
    .upperThresh(upperThresh), .lowerThresh(lowerThresh), .heavyLoad(heavyLoad),
    .nearInput(nearInput), .outputAtLevel(1'h0), .otpValid(otpValid), .otpTarget(otpTarget),
    .otpRate(otpRate), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .highSideOn(highSideOn), .lowSideOn(lowSideOn),
    .bleedOn(bleedOn), .rampLevel(rampLevel), .otpReadReq(otpReadReq), .irq(irq));
  bkrs_stage_model i_bkrs_stage_model (.clk(clk), .highSideOn(highSideOn), .lowSideOn(lowSideOn),
    .otpReadReq(otpReadReq), .tgt(tgt), .rate(rate), .upperThresh(upperThresh),
    .lowerThresh(lowerThresh), .otpValid(otpValid), .otpTarget(otpTarget), .otpRate(otpRate));
  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Count high-side pulses
  always @(posedge clk) if ($rose(highSideOn)) hsRise <= hsRise + 1;
  task wrap_up;
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", s, e, g);
      fails++;
    end
  endtask
  // One-cycle write strobe
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) begin
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'h1;
    end
    @(posedge clk) regWrite <= 1'h0;
  endtask
  // Read data stand one cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk) begin
      regAddr <= a;
      regRead <= 1'h1;
    end
    @(posedge clk) regRead <= 1'h0;
    #1 v = regRdata;
  endtask
  // Poll state, bounded
  task ws(input logic [2:0] s, input int m);
    for (int i = 0; i < m; i++) begin
      rd(4'h3, d);
      if (d[2:0] === s) return;
    end
    chk("state wait", {5'h0, s}, d);
    wrap_up;
  endtask
  initial begin
    tgt = {2'h0, 6'($random(seed))} + 8'h20;
    rate = {2'h0, 2'($random(seed))} + 4'h2;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    rd(4'h0, d);
    chk("setup", 8'h01, d);
    rd(4'hf, d);
    chk("unmapped", 8'h00, d);
    wr(4'h0, 8'h09);
    chipOn <= 1'h1;
    supplyOk <= 1'h1;
    ws(3'h4, 6000);
    chk("target", tgt, rampLevel);
    chk("forced pwm", 8'h40, d & 8'h40);
    chk("switching", 8'h01, {7'h0, hsRise > 0});
    wr(4'h5, 8'h00);
    #1 i0 = irq;
    chk("irq masked", 8'h00, {7'h0, i0});
    wr(4'h5, 8'h07);
    #1 chk("irq mask", 8'h01, {7'h0, irq});
    rd(4'h4, d);
    chk("ready event", 8'h04, d & 8'h04);
    wr(4'h4, 8'h07);
    #1 chk("irq clear", 8'h00, {7'h0, irq});
    wr(4'h0, 8'h01);
    heavyLoad <= 1'h1;
    repeat (4) @(posedge clk);
    rd(4'h3, d);
    chk("auto pwm", 8'h40, d & 8'h40);
    heavyLoad <= 1'h0;
    nearInput <= 1'h1;
    repeat (8) @(posedge clk);
    rd(4'h3, d);
    chk("bypass", 8'h80, d & 8'hc0);
    chk("bypass drives", 8'h00, {6'h0, highSideOn, lowSideOn});
    nearInput <= 1'h0;
    wr(4'h0, 8'h09);
    for (int k = 0; k < 2; k++) begin
      peakLimit <= 1'h1;
      ws(3'h5, 20);
      peakLimit <= 1'h0;
      repeat (40) @(posedge clk);
      rd(4'h3, d);
      chk("hiccup hold", 8'h05, d & 8'h07);
      ws(3'h3, 20);
    end
    rd(4'h4, d);
    chk("oc event", 8'h01, d & 8'h01);
    ws(3'h4, 6000);
    wr(4'h2, 8'h01);
    peakLimit <= 1'h1;
    ws(3'h6, 20);
    peakLimit <= 1'h0;
    repeat (100) @(posedge clk);
    rd(4'h3, d);
    chk("latched", 8'h06, d & 8'h07);
    wr(4'h0, 8'h08);
    ws(3'h0, 10);
    wr(4'h0, 8'h09);
    ws(3'h4, 6000);
    wr(4'h2, 8'h02);
    peakLimit <= 1'h1;
    n = hsRise;
    repeat (200) @(posedge clk);
    rd(4'h3, d);
    chk("limit state", 8'h04, d & 8'h07);
    chk("limit switches", 8'h01, {7'h0, hsRise > n + 5});
    peakLimit <= 1'h0;
    overTemp <= 1'h1;
    ws(3'h7, 20);
    repeat (8) @(posedge clk);
    chk("hot drives", 8'h00, {6'h0, highSideOn, lowSideOn});
    overTemp <= 1'h0;
    ws(3'h3, 20);
    ws(3'h4, 6000);
    chk("hot target", tgt, rampLevel);
    wr(4'h0, 8'h0a);
    repeat (4) @(posedge clk);
    chk("bleed", 8'h01, {7'h0, bleedOn});
    wr(4'h0, 8'h09);
    repeat (300) @(posedge clk);
    chipOn <= 1'h0;
    repeat (5000) @(posedge clk);
    rd(4'h3, d);
    chk("power down", 8'h00, d & 8'h07);
    chk("ramp cleared", 8'h00, rampLevel);
    wrap_up;
  end
endmodule // bkrs_sequencer_tb_top
`default_nettype wire
